// *** logic/batch_warning_monitor.sv ***
`timescale 1ns/1ps
module batch_warning_monitor #(
    parameter int unsigned ON_10HZ_CYC = batch_warn_pkg::ON_10HZ_CYC,
    parameter int unsigned ON_200HZ_CYC = batch_warn_pkg::ON_200HZ_CYC,
    parameter int unsigned GATE_CYC = batch_warn_pkg::GATE_CYC,
    parameter int unsigned BAUD_BASE_CYC = batch_warn_pkg::BAUD_BASE_CYC,
    parameter int unsigned NPTS = 16,
    parameter int unsigned FW = 24
) (
    input wire logic i_mclk,
    input wire logic i_sys_rst,
    input wire logic i_pulse_pin,
    input wire logic i_start_key,
    input wire logic i_clear_key,
    input wire logic i_set_load,
    input wire logic [31:0] i_preset,
    input wire logic [31:0] i_prewarn,
    input wire logic [batch_warn_pkg::KF_W-1:0] i_kfactor,
    input wire logic [NPTS*FW-1:0] i_point_freq,
    input wire logic [1:0] i_out_speed,
    input wire logic i_analog_sel_total,
    input wire logic i_analog_zero_based,
    input wire logic [31:0] i_analog_lo,
    input wire logic [31:0] i_analog_hi,
    input wire logic [3:0] i_unit_addr,
    input wire logic [2:0] i_baud_sel,
    input wire logic [1:0] i_parity_sel,
    input wire logic [7:0] i_lockout_secs,
    input wire logic [15:0] i_lock_code,
    input wire logic i_lock_req,
    input wire logic i_code_strobe,
    input wire logic [15:0] i_code,
    input wire logic [3:0] i_rx_addr,
    input wire logic i_rx_addr_valid,
    input wire logic [7:0] i_tx_byte,
    output logic o_ctl_prewarn,
    output logic o_ctl_final,
    output logic o_start_refused,
    output logic o_settings_refused,
    output logic o_freq_out,
    output logic o_preset_order_fault,
    output logic o_point_order_fault,
    output logic o_overrun_warning,
    output logic o_rate_overflow_warning,
    output logic o_lock_on,
    output logic o_security,
    output batch_warn_pkg::warn_t o_warning,
    output logic [31:0] o_batch_count,
    output logic [31:0] o_rate,
    output logic [14:0] o_current_ua,
    output logic o_addr_match,
    output logic o_parity_bit,
    output logic [15:0] o_baud_div
);
    import batch_warn_pkg::*;
    if (GATE_CYC < 2 || BAUD_BASE_CYC < 32 || BAUD_BASE_CYC > 65535) begin : g_bad_cfg
        $error("batch_warning_monitor gate or baud count out of range");
    end
    // ************************************************************
    // Pin synchronisers and edges
    // ************************************************************
    logic [2:0] sy1_r, sy2_r, sy3_r;
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            sy1_r <= 3'h0;
            sy2_r <= 3'h0;
            sy3_r <= 3'h0;
        end else begin
            sy1_r <= {i_clear_key, i_start_key, i_pulse_pin};
            sy2_r <= sy1_r;
            sy3_r <= sy2_r;
        end
    end
    wire logic pulse_edge = sy2_r[0] && !sy3_r[0];
    wire logic start_edge = sy2_r[1] && !sy3_r[1];
    wire logic clear_edge = sy2_r[2] && !sy3_r[2];
    // ************************************************************
    // Settings store
    // ************************************************************
    logic [31:0] preset_r, prewarn_r, alo_r, ahi_r;
    logic [KF_W-1:0] kf_r;
    logic [NPTS*FW-1:0] pts_r;
    logic [1:0] speed_r, par_r;
    logic asel_r, azero_r;
    logic [3:0] addr_r;
    logic [2:0] baud_r;
    logic [7:0] lsecs_r;
    logic [15:0] lcode_r;
    logic lock_r, security_r;
    // Load gate: locks and bad K-factor or baud refuse it
    wire logic halt = security_r;
    wire logic kf_ok = (i_kfactor >= KF_MIN) && (i_kfactor <= KF_MAX);
    wire logic set_ok = i_set_load && !lock_r && !security_r && kf_ok &&
                        (i_baud_sel <= BAUD_SEL_MAX);
    assign o_settings_refused = i_set_load && !set_ok;
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            preset_r <= PRESET_RST;
            prewarn_r <= PRESET_RST;
            kf_r <= KF_SCALE;
            pts_r <= '0;
            speed_r <= 2'h0;
            asel_r <= 1'b0;
            azero_r <= 1'b0;
            alo_r <= 32'h00000000;
            ahi_r <= 32'h00000000;
            addr_r <= 4'h0;
            baud_r <= 3'h0;
            par_r <= PAR_ODD;
            lsecs_r <= 8'h00;
            lcode_r <= LOCK_CODE_RST;
        end else if (set_ok) begin
            preset_r <= i_preset;
            prewarn_r <= i_prewarn;
            kf_r <= i_kfactor;
            pts_r <= i_point_freq;
            speed_r <= i_out_speed;
            asel_r <= i_analog_sel_total;
            azero_r <= i_analog_zero_based;
            alo_r <= i_analog_lo;
            ahi_r <= i_analog_hi;
            addr_r <= i_unit_addr;
            baud_r <= i_baud_sel;
            par_r <= i_parity_sel;
            lsecs_r <= i_lockout_secs;
            lcode_r <= i_lock_code;
        end
    end
    // ************************************************************
    // Gate tick, idle timer, lock and security
    // ************************************************************
    logic [31:0] gate_r;
    logic [7:0] idle_s_r;
    wire logic gate_tick = (gate_r == GATE_CYC - 1);
    wire logic code_ok = i_code_strobe && (i_code == lcode_r);
    wire logic sec_trip = (lsecs_r != 8'h00) && (idle_s_r >= lsecs_r);
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            gate_r <= 32'h0;
            idle_s_r <= 8'h00;
            lock_r <= 1'b0;
            security_r <= 1'b0;
        end else begin
            gate_r <= gate_tick ? 32'h0 : gate_r + 32'h1;
            if (pulse_edge || code_ok) begin
                idle_s_r <= 8'h00;
            end else if (gate_tick && idle_s_r != 8'hFF) begin
                idle_s_r <= idle_s_r + 8'h01;
            end
            lock_r <= i_lock_req || (lock_r && !code_ok);
            security_r <= (sec_trip && !code_ok) || (security_r && !code_ok);
        end
    end
    // ************************************************************
    // K-factor division and gap check
    // ************************************************************
    logic [KF_W:0] acc_r;
    logic [9:0] gap_r;
    wire logic acc_sat = acc_r[KF_W];
    wire logic add_in = pulse_edge && !halt && !acc_sat;
    wire logic fact = !halt && (acc_r >= {1'b0, kf_r});
    wire logic fast_in = pulse_edge && (gap_r < 10'(MIN_IN_GAP_CYC));
    wire logic [KF_W:0] acc_nxt = acc_r + (add_in ? {1'b0, KF_SCALE} : '0) -
                                  (fact ? {1'b0, kf_r} : '0);
    logic pend_full;
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            acc_r <= '0;
            gap_r <= 10'(MIN_IN_GAP_CYC);
        end else begin
            acc_r <= acc_nxt;
            if (pulse_edge) begin
                gap_r <= 10'h001;
            end else if (gap_r < 10'(MIN_IN_GAP_CYC)) begin
                gap_r <= gap_r + 10'h001;
            end
        end
    end
    // ************************************************************
    // Counts, rate and warnings
    // ************************************************************
    logic [31:0] cnt_r, total_r, rate_acc_r;
    wire logic ovr_set = fast_in || (fact && pend_full) ||
                         (pulse_edge && acc_sat);
    wire logic [31:0] rate_add = (rate_acc_r <= RATE_MAX) ? 32'(fact) : 32'h0;
    logic bad_pts;
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            cnt_r <= 32'h0;
            total_r <= 32'h0;
            rate_acc_r <= 32'h0;
            o_rate <= 32'h0;
            o_rate_overflow_warning <= 1'b0;
            o_overrun_warning <= 1'b0;
            o_preset_order_fault <= 1'b0;
            o_point_order_fault <= 1'b0;
        end else begin
            cnt_r <= (clear_edge ? 32'h0 : cnt_r) + 32'(fact);
            total_r <= total_r + 32'(fact);
            rate_acc_r <= (gate_tick ? 32'h0 : rate_acc_r) + (gate_tick ? 32'(fact) : rate_add);
            if (gate_tick) begin
                o_rate <= rate_acc_r;
                o_rate_overflow_warning <= (rate_acc_r > RATE_MAX);
            end
            o_overrun_warning <= ovr_set || (o_overrun_warning && !clear_edge);
            o_preset_order_fault <= (preset_r < prewarn_r);
            o_point_order_fault <= bad_pts;
        end
    end
    assign o_batch_count = cnt_r;
    point_order_check #(.NPTS(NPTS), .FW(FW)) u_pts (
        .i_freq(pts_r),
        .o_bad(bad_pts)
    );
    pulse_out #(
        .ON0(ON_10HZ_CYC), .ON1(ON_200HZ_CYC), .ON2(ON_2KHZ_CYC),
        .ON3(ON_20KHZ_CYC), .DEPTH(PEND_DEPTH)
    ) u_pout (
        .i_mclk(i_mclk),
        .i_sys_rst(i_sys_rst),
        .i_inc(fact),
        .i_speed(speed_r),
        .o_pulse(o_freq_out),
        .o_full(pend_full)
    );
    // ************************************************************
    // Batch control outputs
    // ************************************************************
    wire logic start_ok = start_edge && !halt && (cnt_r <= preset_r);
    assign o_start_refused = start_edge && !start_ok;
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            o_ctl_prewarn <= 1'b0;
            o_ctl_final <= 1'b0;
        end else begin
            o_ctl_prewarn <= start_ok || (o_ctl_prewarn && !halt && cnt_r < prewarn_r);
            o_ctl_final <= start_ok || (o_ctl_final && !halt && cnt_r < preset_r);
        end
    end
    // ************************************************************
    // Current output scaling
    // ************************************************************
    wire logic [31:0] aval = asel_r ? total_r : o_rate;
    wire logic [14:0] base_ua = azero_r ? 15'h0000 : CUR_4MA_UA;
    wire logic [14:0] span_ua = azero_r ? CUR_20MA_UA : SPAN_4_20_UA;
    wire logic in_span = (ahi_r > alo_r) && (aval > alo_r) && (aval < ahi_r);
    wire logic [63:0] anum = 64'(aval - alo_r) * 64'(span_ua);
    wire logic [63:0] aden = in_span ? 64'(ahi_r - alo_r) : 64'h1;
    wire logic [63:0] aquo = anum / aden;
    wire logic [14:0] cur_nxt = in_span ? base_ua + aquo[14:0] :
                                (ahi_r > alo_r && aval >= ahi_r) ? CUR_20MA_UA : base_ua;
    // ************************************************************
    // Serial addressing, parity and baud
    // ************************************************************
    wire logic par_even = ^i_tx_byte;
    wire logic par_nxt = (par_r == PAR_ODD) ? !par_even : (par_r == PAR_EVEN) ? par_even :
                         (par_r == PAR_MARK);
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            o_current_ua <= CUR_4MA_UA;
            o_addr_match <= 1'b0;
            o_parity_bit <= 1'b0;
            o_baud_div <= 16'h0000;
        end else begin
            o_current_ua <= cur_nxt;
            o_addr_match <= i_rx_addr_valid && (addr_r != 4'h0) && (i_rx_addr == addr_r);
            o_parity_bit <= par_nxt;
            o_baud_div <= 16'(BAUD_BASE_CYC >> baud_r);
        end
    end
    // ************************************************************
    // Warning priority
    // ************************************************************
    assign o_lock_on = lock_r;
    assign o_security = security_r;
    assign o_warning = security_r ? WARN_SECURITY : lock_r ? WARN_LOCK :
                       o_preset_order_fault ? WARN_PRESET_ORDER :
                       o_point_order_fault ? WARN_POINT_ORDER :
                       o_overrun_warning ? WARN_OVERRUN :
                       o_rate_overflow_warning ? WARN_RATE_OVF : WARN_NONE;
    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_sys_rst);
    sequence s_start;
        start_ok;
    endsequence
    sequence s_both_on;
        o_ctl_prewarn && o_ctl_final;
    endsequence
    a_start_both_on: assert property (s_start |=> s_both_on)
        else $error("start did not turn both outputs on");
    a_prewarn_drop: assert property (o_ctl_prewarn && cnt_r >= prewarn_r && !start_ok |=> !o_ctl_prewarn)
        else $error("prewarn output stayed on");
    a_refuse_over: assert property (start_edge && cnt_r > preset_r |-> o_start_refused ##1 !$rose(o_ctl_final))
        else $error("start taken above preset");
    a_preset_fault: assert property (preset_r < prewarn_r |=> o_preset_order_fault)
        else $error("preset order fault missing");
    a_overrun_fast: assert property (fast_in |=> o_overrun_warning)
        else $error("fast input not flagged");
    a_rate_ovf: assert property (gate_tick && rate_acc_r > RATE_MAX |=> o_rate_overflow_warning)
        else $error("rate overflow not flagged");
    a_lock_refuse: assert property (i_set_load && o_lock_on |-> o_settings_refused ##1 $stable(preset_r))
        else $error("settings changed while locked");
    a_security_halt: assert property (security_r |=> !o_ctl_final && !o_ctl_prewarn)
        else $error("outputs on during security halt");
    a_kf_range: assert property (i_set_load && !kf_ok |-> o_settings_refused)
        else $error("out of range K-factor accepted");
    a_fact_div: assert property (fact && !add_in |=> acc_r == $past(acc_r) - {1'b0, $past(kf_r)})
        else $error("factored count did not subtract K-factor");
    a_point_hold: assert property (bad_pts |=> o_point_order_fault)
        else $error("point order fault missing");
    a_addr_match: assert property (o_addr_match |->
        $past(i_rx_addr) == $past(addr_r) && $past(addr_r) != 4'h0)
        else $error("answered a foreign address");
    a_current_max: assert property (o_current_ua <= CUR_20MA_UA)
        else $error("current above full scale");
    a_warn_priority: assert property (lock_r && !security_r |-> o_warning == WARN_LOCK)
        else $error("lock not shown first");
endmodule // batch_warning_monitor

// *** logic/batch_warn_pkg.sv ***
package batch_warn_pkg;

    // ************************************************************
    // Clock and input timing
    // ************************************************************
    localparam int unsigned CLK_HZ = 10000000;
    localparam longint unsigned NS_PER_S = 1000000000;
    localparam int unsigned MAX_IN_HZ = 20000;
    localparam int unsigned MIN_IN_GAP_CYC = CLK_HZ / MAX_IN_HZ;
    localparam int unsigned GATE_S = 1;
    localparam int unsigned GATE_CYC = CLK_HZ * GATE_S;

    // ************************************************************
    // Frequency output least on and off times
    // ************************************************************
    localparam longint unsigned ON_10HZ_NS = 47500000;
    localparam longint unsigned ON_200HZ_NS = 2000000;
    localparam longint unsigned ON_2KHZ_NS = 200000;
    localparam longint unsigned ON_20KHZ_NS = 13000;
    localparam int unsigned ON_10HZ_CYC = int'((ON_10HZ_NS * CLK_HZ + NS_PER_S - 1) / NS_PER_S);
    localparam int unsigned ON_200HZ_CYC = int'((ON_200HZ_NS * CLK_HZ + NS_PER_S - 1) / NS_PER_S);
    localparam int unsigned ON_2KHZ_CYC = int'((ON_2KHZ_NS * CLK_HZ + NS_PER_S - 1) / NS_PER_S);
    localparam int unsigned ON_20KHZ_CYC = int'((ON_20KHZ_NS * CLK_HZ + NS_PER_S - 1) / NS_PER_S);
    localparam int unsigned PEND_DEPTH = 9999;

    // ************************************************************
    // Scaling, limits and reset values
    // ************************************************************
    localparam int unsigned KF_W = 50;
    localparam longint unsigned KF_SCALE_L = 64'h0000000000989680;
    localparam longint unsigned KF_MAX_WHOLE = 64'h0000000005F5E0FF;
    localparam logic [KF_W-1:0] KF_SCALE = KF_W'(KF_SCALE_L);
    localparam logic [KF_W-1:0] KF_MIN = 50'h00000000003E9;
    localparam logic [KF_W-1:0] KF_MAX = KF_W'(KF_MAX_WHOLE * KF_SCALE_L);
    localparam logic [31:0] RATE_MAX = 32'h0098967F;
    localparam logic [14:0] CUR_4MA_UA = 15'h0FA0;
    localparam logic [14:0] CUR_20MA_UA = 15'h4E20;
    localparam logic [14:0] SPAN_4_20_UA = 15'h3E80;
    localparam logic [31:0] PRESET_RST = 32'h00000000;
    localparam logic [15:0] LOCK_CODE_RST = 16'h0000;

    // ************************************************************
    // Serial settings
    // ************************************************************
    localparam int unsigned BAUD_MIN = 300;
    localparam int unsigned BAUD_BASE_CYC = CLK_HZ / BAUD_MIN;
    localparam logic [2:0] BAUD_SEL_MAX = 3'h5;
    localparam logic [1:0] PAR_ODD = 2'h0;
    localparam logic [1:0] PAR_EVEN = 2'h1;
    localparam logic [1:0] PAR_SPACE = 2'h2;
    localparam logic [1:0] PAR_MARK = 2'h3;

    typedef enum logic [2:0] {
        WARN_NONE, WARN_SECURITY, WARN_LOCK, WARN_PRESET_ORDER,
        WARN_POINT_ORDER, WARN_OVERRUN, WARN_RATE_OVF
    } warn_t;

endpackage

// *** logic/point_order_check.sv ***
`timescale 1ns/1ps
module point_order_check #(
    parameter int unsigned NPTS = 16,
    parameter int unsigned FW = 24
) (
    input wire logic [NPTS*FW-1:0] i_freq,
    output logic o_bad
);
    if (NPTS < 3 || FW < 1) begin : g_bad_cfg
        $error("point_order_check needs at least three points");
    end

    // ************************************************************
    // Ascending check, zero at point three or above ends the table
    // ************************************************************
    logic [NPTS-1:0] live;
    logic [NPTS-1:0] bad;
    assign live[0] = 1'b1;
    assign bad[0] = 1'b0;
    for (genvar i = 1; i < NPTS; i++) begin : g_pt
        wire logic [FW-1:0] cur = i_freq[i*FW +: FW];
        wire logic [FW-1:0] prv = i_freq[(i-1)*FW +: FW];
        wire logic stop = (i >= 2) && (cur == '0);
        assign live[i] = live[i-1] && !stop;
        assign bad[i] = live[i] && (cur <= prv);
    end
    assign o_bad = |bad;
endmodule // point_order_check

// *** logic/pulse_out.sv ***
`timescale 1ns/1ps
module pulse_out #(
    parameter int unsigned ON0 = 475000,
    parameter int unsigned ON1 = 20000,
    parameter int unsigned ON2 = 2000,
    parameter int unsigned ON3 = 130,
    parameter int unsigned DEPTH = 9999
) (
    input wire logic i_mclk,
    input wire logic i_sys_rst,
    input wire logic i_inc,
    input wire logic [1:0] i_speed,
    output logic o_pulse,
    output logic o_full
);
    localparam int unsigned PW = $clog2(DEPTH + 1);
    if (DEPTH < 1 || ON3 < 1 || ON2 < 1 || ON1 < 1 || ON0 < 1) begin : g_bad_cfg
        $error("pulse_out needs nonzero depth and times");
    end

    typedef enum logic [1:0] {PO_IDLE, PO_HIGH, PO_LOW} po_state_t;
    po_state_t state_r, state_nxt;
    logic [PW-1:0] pend_r, pend_nxt;
    logic [31:0] tmr_r, tmr_nxt;
    logic [31:0] on_cyc;
    logic go;

    // ************************************************************
    // Speed select and pending store
    // ************************************************************
    assign on_cyc = (i_speed == 2'h0) ? ON0 : (i_speed == 2'h1) ? ON1 :
                    (i_speed == 2'h2) ? ON2 : ON3;
    assign o_full = (pend_r == PW'(DEPTH));
    assign go = (state_r == PO_IDLE) && (pend_r != '0);
    assign pend_nxt = pend_r + PW'(i_inc && !o_full) - PW'(go);

    // Pulse shaper
    always_comb begin
        state_nxt = state_r;
        tmr_nxt = tmr_r;
        unique case (state_r)
            PO_IDLE: if (go) begin
                state_nxt = PO_HIGH;
                tmr_nxt = on_cyc - 32'h1;
            end
            PO_HIGH: if (tmr_r == '0) begin
                state_nxt = PO_LOW;
                tmr_nxt = on_cyc - 32'h1;
            end else begin
                tmr_nxt = tmr_r - 32'h1;
            end
            PO_LOW: if (tmr_r == '0) begin
                state_nxt = PO_IDLE;
            end else begin
                tmr_nxt = tmr_r - 32'h1;
            end
            default: state_nxt = PO_IDLE;
        endcase
    end

    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            state_r <= PO_IDLE;
            pend_r <= '0;
            tmr_r <= '0;
            o_pulse <= 1'b0;
        end else begin
            state_r <= state_nxt;
            pend_r <= pend_nxt;
            tmr_r <= tmr_nxt;
            o_pulse <= (state_nxt == PO_HIGH);
        end
    end

    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_sys_rst);
    a_pend_hold_full: assert property (o_full && !go |=> pend_r == PW'(DEPTH))
        else $error("pending store left full level");
    a_pend_count_up: assert property (i_inc && !o_full && !go |=> pend_r == $past(pend_r) + 1'b1)
        else $error("pending count lost an increment");
endmodule // pulse_out

// *** tb/flow_sensor.sv ***
`timescale 1ns/1ps
module flow_sensor (
    input wire logic i_mclk,
    input wire logic i_go,
    input wire logic [15:0] i_gap,
    output logic o_pulse,
    output logic [15:0] o_sent
);
    int n = 0;
    initial o_pulse = 1'b0;
    initial o_sent = 16'h0000;
    // Two clocks high, then low for the gap; counts pulses sent
    always @(posedge i_mclk) begin
        o_pulse <= i_go && n < 2;
        n <= (!i_go || n > i_gap) ? 0 : n + 1;
        if (i_go && n == 0) begin
            o_sent <= o_sent + 16'h0001;
        end
    end
endmodule // flow_sensor

// *** tb/tb.sv ***
`timescale 1ns/1ps
module tb;
    import batch_warn_pkg::*;
    `define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin mismatches++; \
        $display("mismatch %s exp %0h got %0h", n, e, g); end end
    logic clk = 0, rst = 1, st = 0, clr = 0, ld = 0, lrq = 0, cs = 0, av = 0, go = 0, pin;
    logic sr, po, pt, ov, lk, am, par, sec, fo, fo_d = 0, asel = 0, az = 0;
    wire [1:0] c;
    logic [1:0] ps = 0;
    logic [31:0] pre = 0, pw = 0, cnt, s = 32'h0807;
    logic [49:0] kf = KF_SCALE;
    logic [383:0] tbl = 0;
    logic [15:0] gap = 16'h0258, sent, bd, cd = 16'h0000, ce = 16'h0000;
    logic [14:0] cur;
    logic [3:0] ra = 0, ua = 0;
    logic [7:0] tx = 0, ls = 8'h00;
    logic [2:0] bs = 0;
    warn_t wr;
    int mismatches = 0, n_compared = 0, nf = 0;
    always #50 clk = ~clk;
    flow_sensor flow_sensor_i (.i_mclk(clk), .i_go(go), .i_gap(gap), .o_pulse(pin),
        .o_sent(sent));
    batch_warning_monitor #(.ON_10HZ_CYC(20), .ON_200HZ_CYC(10), .GATE_CYC(100))
        batch_warning_monitor_i (.i_mclk(clk), .i_sys_rst(rst), .i_pulse_pin(pin),
        .i_start_key(st), .i_clear_key(clr), .i_set_load(ld), .i_preset(pre), .i_prewarn(pw),
        .i_kfactor(kf), .i_point_freq(tbl), .i_out_speed(ps), .i_analog_sel_total(asel),
        .i_analog_zero_based(az), .i_analog_lo(32'h0), .i_analog_hi(pre),
        .i_unit_addr(ua), .i_baud_sel(bs), .i_parity_sel(ps), .i_lockout_secs(ls),
        .i_lock_code(cd), .i_lock_req(lrq), .i_code_strobe(cs), .i_code(ce),
        .i_rx_addr(ra), .i_rx_addr_valid(av), .i_tx_byte(tx), .o_ctl_prewarn(c[1]),
        .o_ctl_final(c[0]), .o_start_refused(), .o_settings_refused(sr), .o_freq_out(fo),
        .o_preset_order_fault(po), .o_point_order_fault(pt), .o_overrun_warning(ov),
        .o_rate_overflow_warning(), .o_lock_on(lk), .o_security(sec), .o_warning(wr),
        .o_batch_count(cnt), .o_current_ua(cur), .o_addr_match(am), .o_parity_bit(par),
        .o_baud_div(bd), .o_rate());
    // Counts scaled output pulses
    always @(posedge clk) begin
        fo_d <= fo;
        if (fo && !fo_d) nf <= nf + 1;
    end
    // Xorshift source and expected parity
    function automatic logic [31:0] xs();
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        s = s ^ (s << 5);
        return s;
    endfunction
    function automatic logic pbit(input logic [1:0] m, input logic [7:0] d);
        return (m == PAR_ODD) ? ~^d : (m == PAR_EVEN) ? ^d : (m == PAR_MARK);
    endfunction
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #10;
    endtask
    task automatic key(ref logic k);
        k = 1;
        cyc(4);
        k = 0;
        cyc(2);
    endtask
    task automatic set(input logic [31:0] p, w, input logic [49:0] k, input logic [2:0] b,
            input logic e);
        {pre, pw, kf, bs, ld} = {p, w, k, b, 1'b1};
        #30 `CHK("refused", e, sr)
        cyc(1);
        ld = 0;
        cyc(2);
    endtask
    task automatic upto(input logic [15:0] n);
        for (int i = 0; i < 9000 && sent < n; i++) cyc(1);
        if (sent < n) begin
            mismatches++;
            wrap_up();
        end
        cyc(12);
    endtask
    task automatic wrap_up;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        for (int k = 0; k < 16; k++) tbl[k*24 +: 24] = 24'(k * 100 + 5);
        cyc(3);
        rst = 0;
        cyc(2);
        `CHK("cur", CUR_4MA_UA, cur)
        `CHK("baud", 16'(BAUD_BASE_CYC), bd)
        `CHK("ptord", 1'b1, pt)
        $display("test reset done");
        for (int b = 0; b < 6; b++) begin
            set(10, 20, KF_SCALE, 3'(b), 0);
            `CHK("baud", 16'(BAUD_BASE_CYC >> b), bd)
        end
        `CHK("order", 1'b1, po)
        `CHK("ptord", 1'b0, pt)
        `CHK("warn", WARN_PRESET_ORDER, wr)
        set(10, 20, KF_MIN - 50'h1, 0, 1);
        set(10, 20, KF_MAX + 50'h1, 0, 1);
        set(10, 20, KF_SCALE, 6, 1);
        $display("test settings done");
        key(lrq);
        `CHK("warn", WARN_LOCK, wr)
        set(3, 2, KF_SCALE, 0, 1);
        `CHK("lock", 1'b1, lk)
        key(cs);
        `CHK("lock", 1'b0, lk)
        $display("test lock done");
        cd = 16'(xs());
        set(3, 2, KF_SCALE >> 1, 0, 0);
        `CHK("order", 1'b0, po)
        key(st);
        `CHK("ctl", 2'b11, c)
        go = 1;
        upto(1);
        `CHK("count", 32'h2, cnt)
        `CHK("ctl", 2'b01, c)
        upto(2);
        go = 0;
        `CHK("ctl", 2'b00, c)
        `CHK("ovr", 1'b0, ov)
        key(st);
        `CHK("ctl", 2'b00, c)
        key(clr);
        `CHK("count", 32'h0, cnt)
        key(st);
        `CHK("ctl", 2'b11, c)
        gap = 16'h0064;
        go = 1;
        upto(4);
        go = 0;
        `CHK("ovr", 1'b1, ov)
        `CHK("warn", WARN_OVERRUN, wr)
        $display("test batch done");
        {asel, az} = 2'b11;
        set(16, 2, KF_SCALE >> 1, 0, 0);
        `CHK("cur", 15'h2710, cur)
        $display("test current done");
        for (int i = 0; i < 8; i++) begin
            {ps, ua, tx} = {2'(i), 4'(xs()), 8'(xs())};
            set(3, 2, KF_SCALE, 0, 0);
            ra = i[0] ? ua : 4'(xs());
            av = 1;
            cyc(1);
            av = 0;
            `CHK("addr", ra == ua && ua != 0, am)
            `CHK("parity", pbit(ps, tx), par)
        end
        $display("test serial done");
        ls = 8'h02;
        set(3, 2, KF_SCALE, 0, 0);
        cyc(5000);
        `CHK("sec", 1'b1, sec)
        `CHK("warn", WARN_SECURITY, wr)
        `CHK("fout", 32'h8, nf)
        key(clr);
        key(st);
        `CHK("ctl", 2'b00, c)
        set(3, 2, KF_SCALE, 0, 1);
        ce = ~cd;
        key(cs);
        `CHK("sec", 1'b1, sec)
        ce = cd;
        key(cs);
        `CHK("sec", 1'b0, sec)
        $display("test security done");
        wrap_up();
    end
endmodule // tb
